// ==== dps_pkg.sv ====
package dps_pkg;

  localparam int PORTS = 2;
  localparam int LANES = 2;
  localparam int DW_WIDE = 36;
  localparam int DW_NARROW = 18;
  localparam int INV_MAX_W = 18;
  localparam int BURST = 2;
  localparam int RD_LAT_DEF = 5;
  localparam int RD_LAT_MIN = 3;
  localparam int AW_DEF = 6;
  localparam int CFG_W = 8;
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam logic [CFG_W-1:0] CFG_RST = 8'h00;

  // a lane is sent inverted when more than half of its bits would be low
  function automatic logic dps_inv_needed(input logic [INV_MAX_W-1:0] v, input int lw);
    int z;
    z = 0;
    for (int i = 0; i < INV_MAX_W; i++) begin
      if (i < lw && !v[i]) begin
        z++;
      end
    end
    return z >= lw / 2 + 1;
  endfunction

endpackage

// ==== dps_mem.sv ====
`timescale 1ns/1ps
module dps_mem #(
  parameter int AW = 7,
  parameter int DW = 36
) (
  input wire logic clk_w,
  input wire logic we_a,
  input wire logic [AW-1:0] waddr_a,
  input wire logic [DW-1:0] wdata_a,
  input wire logic we_b,
  input wire logic [AW-1:0] waddr_b,
  input wire logic [DW-1:0] wdata_b,
  input wire logic clk_ra,
  input wire logic [AW-1:0] raddr_a,
  output logic [DW-1:0] rdata_a,
  input wire logic clk_rb,
  input wire logic [AW-1:0] raddr_b,
  output logic [DW-1:0] rdata_b
);

  logic [DW-1:0] mem [2**AW];

  // both write ports in one process; port a wins a same-word collision
  always_ff @(posedge clk_w) begin
    if (we_a) begin
      mem[waddr_a] <= wdata_a;
    end
    if (we_b && !(we_a && waddr_a == waddr_b)) begin
      mem[waddr_b] <= wdata_b;
    end
  end

  always_ff @(posedge clk_ra) begin
    rdata_a <= mem[raddr_a];
  end

  always_ff @(posedge clk_rb) begin
    rdata_b <= mem[raddr_b];
  end

endmodule

// ==== dps_top.sv ====
`timescale 1ns/1ps
// Functional notes
// (RULE1) write data captured per lane, each lane timed by its own write clock
// (RULE2) read data driven per lane, each lane with its own read clock
// (RULE3) two-bit inversion flag per port, bit 0 lower lane, bit 1 upper
// (RULE4) data bus bidirectional, 36 bits wide or 18 bits narrow
// (RULE5) port a load strobe on rising command clock, port b on falling
// (RULE6) low load strobe accepts commands; high ignores them, work in flight continues; a write issued while one is still pending is dropped
// (RULE7) read/write select sampled on its port edge, decoded with load strobe
// (RULE8) load low with select high reads, select low writes
// (RULE9) per-lane read valid, edge-aligned with that lane's read clock
// (RULE10) read valid rises half cycle before first word, falls before last
// (RULE11) active-low reset input resets asynchronously, independent of command clock
// (RULE12) config select qualifies commands as configuration register accesses
// (RULE13) rising edge samples port a controls and address, falling edge port b
// (RULE14) width parameter sets lane width, bus width and inversion coverage for both ports; always two lanes
// (RULE15) ports independent; one port never blocks or alters the other; a same-word array write or same-cycle config write of port b loses to port a
module dps_top #(
  parameter bit WIDE_BUS = 1'b1,
  parameter int ADDR_W = dps_pkg::AW_DEF,
  parameter int RD_LAT = dps_pkg::RD_LAT_DEF,
  parameter bit INV_EN = 1'b1,
  localparam int DW = WIDE_BUS ? dps_pkg::DW_WIDE : dps_pkg::DW_NARROW
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic command_clock,
  input wire logic reset_n,
  input wire logic config_select_n,
  input wire logic [ADDR_W-1:0] address_bus,
  input wire logic load_strobe_a_n,
  input wire logic read_write_sel_a_n,
  input wire logic load_strobe_b_n,
  input wire logic read_write_sel_b_n,
  input wire logic [dps_pkg::LANES-1:0] write_clock_port_a,
  input wire logic [dps_pkg::LANES-1:0] write_clock_port_b,
  output logic [dps_pkg::LANES-1:0] read_clock_port_a,
  output logic [dps_pkg::LANES-1:0] read_clock_port_b,
  output logic [dps_pkg::LANES-1:0] read_valid_port_a,
  output logic [dps_pkg::LANES-1:0] read_valid_port_b,
  input wire logic [DW-1:0] data_bus_port_a_i,
  output logic [DW-1:0] data_bus_port_a_o,
  output logic [DW-1:0] data_bus_port_a_oe_n,
  input wire logic [DW-1:0] data_bus_port_b_i,
  output logic [DW-1:0] data_bus_port_b_o,
  output logic [DW-1:0] data_bus_port_b_oe_n,
  input wire logic [dps_pkg::LANES-1:0] data_invert_port_a_i,
  output logic [dps_pkg::LANES-1:0] data_invert_port_a_o,
  output logic [dps_pkg::LANES-1:0] data_invert_port_a_oe_n,
  input wire logic [dps_pkg::LANES-1:0] data_invert_port_b_i,
  output logic [dps_pkg::LANES-1:0] data_invert_port_b_o,
  output logic [dps_pkg::LANES-1:0] data_invert_port_b_oe_n,
  output logic [dps_pkg::CFG_W-1:0] mode_value
);
  import dps_pkg::*;

  localparam int LW = DW / LANES; // RULE14

  logic pclk [PORTS];
  logic [PORTS-1:0] ld_n;
  logic [PORTS-1:0] rw_n;
  logic [LANES-1:0] wck_in [PORTS];
  logic [DW-1:0] dq_in [PORTS];
  logic [LANES-1:0] inv_in [PORTS];
  logic [DW-1:0] dq_out [PORTS];
  logic [DW-1:0] dq_oe_n [PORTS];
  logic [LANES-1:0] inv_out [PORTS];
  logic [LANES-1:0] inv_oe_n [PORTS];
  logic [LANES-1:0] vld_out [PORTS];
  logic [LANES-1:0] rck_out [PORTS];
  logic [PORTS-1:0] mem_we;
  logic [ADDR_W:0] mem_waddr [PORTS];
  logic [DW-1:0] mem_wdata [PORTS];
  logic [ADDR_W:0] mem_raddr [PORTS];
  logic [DW-1:0] mem_rdata [PORTS];
  logic [PORTS-1:0] cfg_we;
  logic [CFG_W-1:0] cfg_wdata [PORTS];
  logic [CFG_W-1:0] cfg_q, cfg_d;
  logic cfg_tgl_q, cfg_tgl_d;
  logic tgl_s1_q, tgl_s2_q, tgl_s3_q;
  logic [CFG_W-1:0] mode_q, mode_d;

  assign pclk[PORT_A] = command_clock; // RULE5 RULE13
  assign pclk[PORT_B] = ~command_clock; // RULE5 RULE13
  assign ld_n = {load_strobe_b_n, load_strobe_a_n};
  assign rw_n = {read_write_sel_b_n, read_write_sel_a_n};
  assign wck_in[PORT_A] = write_clock_port_a;
  assign wck_in[PORT_B] = write_clock_port_b;
  assign dq_in[PORT_A] = data_bus_port_a_i; // RULE4
  assign dq_in[PORT_B] = data_bus_port_b_i;
  assign inv_in[PORT_A] = data_invert_port_a_i;
  assign inv_in[PORT_B] = data_invert_port_b_i;
  assign data_bus_port_a_o = dq_out[PORT_A];
  assign data_bus_port_b_o = dq_out[PORT_B];
  assign data_bus_port_a_oe_n = dq_oe_n[PORT_A];
  assign data_bus_port_b_oe_n = dq_oe_n[PORT_B];
  assign data_invert_port_a_o = inv_out[PORT_A];
  assign data_invert_port_b_o = inv_out[PORT_B];
  assign data_invert_port_a_oe_n = inv_oe_n[PORT_A];
  assign data_invert_port_b_oe_n = inv_oe_n[PORT_B];
  assign read_valid_port_a = vld_out[PORT_A];
  assign read_valid_port_b = vld_out[PORT_B];
  assign read_clock_port_a = rck_out[PORT_A];
  assign read_clock_port_b = rck_out[PORT_B];
  assign mode_value = mode_q;

  for (genvar p = 0; p < PORTS; p++) begin : g_port
    logic [LANES-1:0] wck_s1_q, wck_s2_q, wck_s3_q;
    logic [DW-1:0] dq_s1_q, dq_s2_q;
    logic [LANES-1:0] inv_s1_q, inv_s2_q;
    logic [RD_LAT:0] rd_sh_q, rd_sh_d, rcfg_sh_q, rcfg_sh_d;
    logic [ADDR_W-1:0] raddr_sh_q [RD_LAT+1];
    logic [ADDR_W-1:0] raddr_sh_d [RD_LAT+1];
    logic [ADDR_W:0] mraddr_q, mraddr_d;
    logic [DW-1:0] dqo_q, dqo_d, dqoe_n_q, dqoe_n_d;
    logic [LANES-1:0] invo_q, invo_d, invoe_n_q, invoe_n_d;
    logic wr_pend_q, wr_pend_d, wr_cfg_q, wr_cfg_d, wr_word_q, wr_word_d;
    logic [ADDR_W-1:0] wr_addr_q, wr_addr_d;
    logic [DW-1:0] lbuf_q, lbuf_d;
    logic [LANES-1:0] lhave_q, lhave_d;
    logic mwe_q, mwe_d, cwe_q, cwe_d;
    logic [ADDR_W:0] mwa_q, mwa_d;
    logic [DW-1:0] mwd_q, mwd_d;
    logic [CFG_W-1:0] cwd_q, cwd_d;
    logic [LANES-1:0] vld_q, vld_d, rck_q, rck_d;
    logic accept, finishing, cfg_now, flag;
    logic [LW-1:0] lane;

    always_comb begin
      accept = ~ld_n[p]; // RULE6
      lane = '0;
      flag = 1'b0;
      rd_sh_d = {rd_sh_q[RD_LAT-1:0], accept & rw_n[p]}; // RULE7 RULE8
      rcfg_sh_d = {rcfg_sh_q[RD_LAT-1:0], accept & rw_n[p] & ~config_select_n}; // RULE12
      raddr_sh_d[0] = address_bus; // RULE13
      for (int i = 1; i <= RD_LAT; i++) begin
        raddr_sh_d[i] = raddr_sh_q[i-1];
      end
      // array word address is leads the driven word by two edges
      mraddr_d = mraddr_q;
      if (rd_sh_q[RD_LAT-RD_LAT_MIN]) begin
        mraddr_d = {raddr_sh_q[RD_LAT-RD_LAT_MIN], 1'b0};
      end else if (rd_sh_q[RD_LAT-2]) begin
        mraddr_d = {raddr_sh_q[RD_LAT-2], 1'b1};
      end
      dqo_d = dqo_q;
      invo_d = '0;
      dqoe_n_d = '1;
      invoe_n_d = '1;
      cfg_now = rd_sh_q[RD_LAT-1] ? rcfg_sh_q[RD_LAT-1] : rcfg_sh_q[RD_LAT];
      if (rd_sh_q[RD_LAT-1] | rd_sh_q[RD_LAT]) begin
        if (cfg_now) begin
          // register data on the low bits only, flag forced low, rest released
          dqo_d = DW'(cfg_q); // RULE12
          dqoe_n_d = ~DW'({CFG_W{1'b1}});
          invoe_n_d = {{(LANES-1){1'b1}}, 1'b0};
        end else begin
          dqoe_n_d = '0;
          invoe_n_d = '0;
          for (int l = 0; l < LANES; l++) begin
            lane = mem_rdata[p][l*LW +: LW]; // RULE2
            flag = INV_EN & dps_inv_needed(INV_MAX_W'(lane), LW); // RULE3
            dqo_d[l*LW +: LW] = lane ^ {LW{flag}};
            invo_d[l] = flag;
          end
        end
      end
      vld_d = {LANES{rd_sh_q[RD_LAT-1]}}; // RULE9 RULE10
      rck_d = (rd_sh_q[RD_LAT-1] | rd_sh_q[RD_LAT]) ? ~rck_q : rck_q; // RULE9
      wr_pend_d = wr_pend_q;
      wr_cfg_d = wr_cfg_q;
      wr_word_d = wr_word_q;
      wr_addr_d = wr_addr_q;
      lbuf_d = lbuf_q;
      lhave_d = lhave_q;
      mwe_d = 1'b0;
      cwe_d = 1'b0;
      mwa_d = mwa_q;
      mwd_d = mwd_q;
      cwd_d = cwd_q;
      finishing = wr_pend_q & (&lhave_q) & wr_word_q;
      if (wr_pend_q && (&lhave_q)) begin
        lhave_d = '0;
        if (wr_cfg_q) begin
          cwe_d = ~wr_word_q; // RULE12
          cwd_d = lbuf_q[CFG_W-1:0];
        end else begin
          mwe_d = 1'b1;
          mwa_d = {wr_addr_q, wr_word_q};
          mwd_d = lbuf_q;
        end
        wr_word_d = ~wr_word_q;
        wr_pend_d = ~wr_word_q;
      end
      // a lane edge in the first word's clearing cycle still lands: set wins over clear
      for (int l = 0; l < LANES; l++) begin
        if (wr_pend_q && !finishing && wck_s2_q[l] && !wck_s3_q[l]) begin
          lbuf_d[l*LW +: LW] = dq_s2_q[l*LW +: LW] ^ {LW{inv_s2_q[l]}}; // RULE1 RULE3
          lhave_d[l] = 1'b1; // RULE1
        end
      end
      // one write in flight per port; a second one before it completes is dropped
      if (accept && !rw_n[p] && !wr_pend_q) begin // RULE7 RULE8
        wr_pend_d = 1'b1;
        wr_cfg_d = ~config_select_n; // RULE12
        wr_word_d = 1'b0;
        wr_addr_d = address_bus;
      end
    end

    always_ff @(posedge pclk[p] or negedge reset_n) begin // RULE11
      if (!reset_n) begin
        wck_s1_q <= '0;
        wck_s2_q <= '0;
        wck_s3_q <= '0;
        dq_s1_q <= '0;
        dq_s2_q <= '0;
        inv_s1_q <= '0;
        inv_s2_q <= '0;
        rd_sh_q <= '0;
        rcfg_sh_q <= '0;
        raddr_sh_q <= '{default: '0};
        mraddr_q <= '0;
        dqo_q <= '0;
        dqoe_n_q <= '1;
        invo_q <= '0;
        invoe_n_q <= '1;
        wr_pend_q <= 1'b0;
        wr_cfg_q <= 1'b0;
        wr_word_q <= 1'b0;
        wr_addr_q <= '0;
        lbuf_q <= '0;
        lhave_q <= '0;
        mwe_q <= 1'b0;
        mwa_q <= '0;
        mwd_q <= '0;
        cwe_q <= 1'b0;
        cwd_q <= '0;
      end else begin
        wck_s1_q <= wck_in[p];
        wck_s2_q <= wck_s1_q;
        wck_s3_q <= wck_s2_q;
        dq_s1_q <= dq_in[p];
        dq_s2_q <= dq_s1_q;
        inv_s1_q <= inv_in[p];
        inv_s2_q <= inv_s1_q;
        rd_sh_q <= rd_sh_d;
        rcfg_sh_q <= rcfg_sh_d;
        raddr_sh_q <= raddr_sh_d;
        mraddr_q <= mraddr_d;
        dqo_q <= dqo_d;
        dqoe_n_q <= dqoe_n_d;
        invo_q <= invo_d;
        invoe_n_q <= invoe_n_d;
        wr_pend_q <= wr_pend_d;
        wr_cfg_q <= wr_cfg_d;
        wr_word_q <= wr_word_d;
        wr_addr_q <= wr_addr_d;
        lbuf_q <= lbuf_d;
        lhave_q <= lhave_d;
        mwe_q <= mwe_d;
        mwa_q <= mwa_d;
        mwd_q <= mwd_d;
        cwe_q <= cwe_d;
        cwd_q <= cwd_d;
      end
    end

    // valid and read clock move on the opposite edge, half a cycle ahead of data
    always_ff @(negedge pclk[p] or negedge reset_n) begin // RULE11
      if (!reset_n) begin
        vld_q <= '0;
        rck_q <= '0;
      end else begin
        vld_q <= vld_d;
        rck_q <= rck_d;
      end
    end

    assign dq_out[p] = dqo_q;
    assign dq_oe_n[p] = dqoe_n_q;
    assign inv_out[p] = invo_q;
    assign inv_oe_n[p] = invoe_n_q;
    assign vld_out[p] = vld_q;
    assign rck_out[p] = rck_q;
    assign mem_we[p] = mwe_q;
    assign mem_waddr[p] = mwa_q;
    assign mem_wdata[p] = mwd_q;
    assign mem_raddr[p] = mraddr_q;
    assign cfg_we[p] = cwe_q;
    assign cfg_wdata[p] = cwd_q;
  end

  dps_mem #(
    .AW(ADDR_W + 1),
    .DW(DW)
  ) u_mem (
    .clk_w(command_clock),
    .we_a(mem_we[PORT_A]), // RULE15
    .waddr_a(mem_waddr[PORT_A]),
    .wdata_a(mem_wdata[PORT_A]),
    .we_b(mem_we[PORT_B]), // RULE15
    .waddr_b(mem_waddr[PORT_B]),
    .wdata_b(mem_wdata[PORT_B]),
    .clk_ra(pclk[PORT_A]),
    .raddr_a(mem_raddr[PORT_A]),
    .rdata_a(mem_rdata[PORT_A]),
    .clk_rb(pclk[PORT_B]),
    .raddr_b(mem_raddr[PORT_B]),
    .rdata_b(mem_rdata[PORT_B])
  );

  always_comb begin
    cfg_d = cfg_q;
    cfg_tgl_d = cfg_tgl_q;
    if (cfg_we[PORT_A]) begin
      cfg_d = cfg_wdata[PORT_A];
      cfg_tgl_d = ~cfg_tgl_q;
    end else if (cfg_we[PORT_B]) begin
      cfg_d = cfg_wdata[PORT_B];
      cfg_tgl_d = ~cfg_tgl_q;
    end
  end

  always_ff @(posedge command_clock or negedge reset_n) begin // RULE11
    if (!reset_n) begin
      cfg_q <= CFG_RST;
      cfg_tgl_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      cfg_tgl_q <= cfg_tgl_d;
    end
  end

  // toggle crossing; cfg_q has long settled by the time the toggle arrives
  always_comb begin
    mode_d = (tgl_s2_q ^ tgl_s3_q) ? cfg_q : mode_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_s3_q <= 1'b0;
      mode_q <= CFG_RST;
    end else begin
      tgl_s1_q <= cfg_tgl_q;
      tgl_s2_q <= tgl_s1_q;
      tgl_s3_q <= tgl_s2_q;
      mode_q <= mode_d;
    end
  end

endmodule

// ==== dps_top_assertions.sv ====
`timescale 1ns/1ps
module dps_chk #(
  parameter bit WIDE_BUS = 1'b1,
  localparam int DW = WIDE_BUS ? dps_pkg::DW_WIDE : dps_pkg::DW_NARROW
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic command_clock,
  input wire logic reset_n,
  input wire logic config_select_n,
  input wire logic load_strobe_a_n,
  input wire logic read_write_sel_a_n,
  input wire logic load_strobe_b_n,
  input wire logic read_write_sel_b_n,
  input wire logic [1:0] read_clock_port_a,
  input wire logic [1:0] read_clock_port_b,
  input wire logic [1:0] read_valid_port_a,
  input wire logic [1:0] read_valid_port_b,
  input wire logic [DW-1:0] data_bus_port_a_oe_n,
  input wire logic [1:0] data_invert_port_a_oe_n
);
  property p_rd_a;
    @(posedge command_clock) disable iff (!reset_n)
    !load_strobe_a_n && read_write_sel_a_n && config_select_n |->
    ##5 read_valid_port_a == 2'b11 ##1 read_valid_port_a == 2'b00;
  endproperty
  a_rd_a: assert property (p_rd_a)
    else $error("port a read valid out of place");
  property p_rd_b;
    @(negedge command_clock) disable iff (!reset_n)
    !load_strobe_b_n && read_write_sel_b_n && config_select_n |->
    ##5 read_valid_port_b == 2'b11 ##1 read_valid_port_b == 2'b00;
  endproperty
  a_rd_b: assert property (p_rd_b)
    else $error("port b read valid out of place");
  property p_oe_a;
    @(posedge command_clock) disable iff (!reset_n)
    !load_strobe_a_n && read_write_sel_a_n && config_select_n |->
    ##6 !data_bus_port_a_oe_n[DW-1] [*2];
  endproperty
  a_oe_a: assert property (p_oe_a)
    else $error("port a read data not driven");
  property p_qclk;
    @(posedge command_clock) disable iff (!reset_n)
    read_clock_port_a == read_valid_port_a;
  endproperty
  a_qclk: assert property (p_qclk)
    else $error("read valid not aligned with read clock");
  property p_qclk_b;
    @(negedge command_clock) disable iff (!reset_n)
    read_clock_port_b == read_valid_port_b;
  endproperty
  a_qclk_b: assert property (p_qclk_b)
    else $error("port b read valid not aligned with read clock");
  property p_fall;
    @(posedge command_clock) disable iff (!reset_n)
    $rose(read_valid_port_a[0]) |=> !read_valid_port_a[0] && !data_bus_port_a_oe_n[0];
  endproperty
  a_fall: assert property (p_fall)
    else $error("read valid did not fall before last word");
  property p_ign;
    @(posedge command_clock) disable iff (!reset_n)
    load_strobe_a_n [*5] |=> read_valid_port_a == 2'b00;
  endproperty
  a_ign: assert property (p_ign)
    else $error("read valid without accepted command");
  property p_rst;
    @(posedge clk) disable iff (sys_rst)
    !reset_n |-> &data_bus_port_a_oe_n && read_valid_port_b == 2'b00;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs active during reset");
  property p_inv;
    @(negedge command_clock) disable iff (!reset_n)
    data_invert_port_a_oe_n == {data_bus_port_a_oe_n[DW-1], data_bus_port_a_oe_n[0]};
  endproperty
  a_inv: assert property (p_inv)
    else $error("inversion flag drive differs from its lane");
endmodule

// ==== dps_ctrl_model.sv ====
`timescale 1ns/1ps
module dps_ctrl_model #(
  parameter int DW = 36,
  parameter bit ON_RISE = 1'b0
) (
  input wire logic command_clock,
  output logic [1:0] wclk,
  output logic [DW-1:0] dq,
  output logic [1:0] inv
);
  localparam int LW = DW / 2;
  initial begin
    wclk = 2'b00;
    dq = '0;
    inv = 2'b00;
  end
  function automatic logic [DW+1:0] enc(input logic [DW-1:0] v);
    logic [1:0] f;
    logic [DW-1:0] o;
    o = v;
    for (int l = 0; l < 2; l++) begin
      f[l] = LW - $countones(v[l*LW +: LW]) >= LW / 2 + 1;
      if (f[l]) begin
        o[l*LW +: LW] = ~v[l*LW +: LW];
      end
    end
    return {f, o};
  endfunction
  // port b samples on the falling edge, so its lanes move on the rising one
  task automatic tick();
    if (ON_RISE) begin
      @(posedge command_clock);
    end else begin
      @(negedge command_clock);
    end
  endtask
  task automatic send(input logic [DW-1:0] w0, input logic [DW-1:0] w1);
    for (int i = 0; i < 2; i++) begin
      tick();
      {inv, dq} <= enc(i ? w1 : w0);
      repeat (3) tick();
      wclk <= 2'b11;
      repeat (4) tick();
      wclk <= 2'b00;
      repeat (2) tick();
    end
    // released lines must not keep the last word
    dq <= ~dq;
    inv <= ~inv;
  endtask
endmodule

// ==== test_dps_top.sv ====
`timescale 1ns/1ps
module test_dps_top;
  localparam int W = 36;
  logic clk = 0, sys_rst = 1, cc = 0, reset_n = 0, cfg_n = 1;
  logic lda_n = 1, rwa_n = 1, ldb_n = 1, rwb_n = 1;
  logic [5:0] addr = '0;
  logic [1:0] wca, wcb, qca, qcb, qva, qvb, ia_p, ib_p, ia_o, ib_o, ia_oe, ib_oe;
  logic [W-1:0] da_p, db_p, da_o, db_o, da_oe, db_oe;
  logic [7:0] mode;
  wire [W-1:0] da = (da_o & ~da_oe) | (da_p & da_oe);
  wire [W-1:0] db = (db_o & ~db_oe) | (db_p & db_oe);
  wire [1:0] ia = (ia_o & ~ia_oe) | (ia_p & ia_oe);
  wire [1:0] ib = (ib_o & ~ib_oe) | (ib_p & ib_oe);
  int fail_count = 0;
  int num_checks = 0;
  always #25 clk = ~clk;
  initial begin
    #1.3;
    forever #3 cc = ~cc;
  end
  dps_ctrl_model #(.DW(W), .ON_RISE(1'b0)) pa (.command_clock(cc), .wclk(wca), .dq(da_p), .inv(ia_p));
  dps_ctrl_model #(.DW(W), .ON_RISE(1'b1)) pb (.command_clock(cc), .wclk(wcb), .dq(db_p), .inv(ib_p));
  dps_top #(.WIDE_BUS(1'b1)) dut_u (.clk(clk), .sys_rst(sys_rst), .command_clock(cc),
    .reset_n(reset_n), .config_select_n(cfg_n), .address_bus(addr), .load_strobe_a_n(lda_n),
    .read_write_sel_a_n(rwa_n), .load_strobe_b_n(ldb_n), .read_write_sel_b_n(rwb_n),
    .write_clock_port_a(wca), .write_clock_port_b(wcb), .read_clock_port_a(qca),
    .read_clock_port_b(qcb), .read_valid_port_a(qva), .read_valid_port_b(qvb),
    .data_bus_port_a_i(da), .data_bus_port_a_o(da_o), .data_bus_port_a_oe_n(da_oe),
    .data_bus_port_b_i(db), .data_bus_port_b_o(db_o), .data_bus_port_b_oe_n(db_oe),
    .data_invert_port_a_i(ia), .data_invert_port_a_o(ia_o), .data_invert_port_a_oe_n(ia_oe),
    .data_invert_port_b_i(ib), .data_invert_port_b_o(ib_o), .data_invert_port_b_oe_n(ib_oe),
    .mode_value(mode));
  task automatic test_done();
    $display("checks=%0d fails=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [W+1:0] got, input logic [W+1:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pe(input bit b);
    if (b) begin
      @(posedge cc);
    end else begin
      @(negedge cc);
    end
  endtask
  task automatic cmd(input bit b, input logic ld, input logic rw, input logic cf,
                     input logic [5:0] ad);
    pe(b);
    addr <= ad;
    cfg_n <= cf;
    if (b) begin
      ldb_n <= ld;
      rwb_n <= rw;
    end else begin
      lda_n <= ld;
      rwa_n <= rw;
    end
    pe(b);
    lda_n <= b ? lda_n : 1'b1;
    ldb_n <= b ? 1'b1 : ldb_n;
    cfg_n <= 1'b1;
  endtask
  task automatic rd(input bit b, input logic [5:0] ad, input logic [W-1:0] w0,
                    input logic [W-1:0] w1);
    cmd(b, 1'b0, 1'b1, 1'b1, ad);
    repeat (5) pe(b);
    chk(b ? {ib_o, db_o} : {ia_o, da_o}, pa.enc(w0));
    chk({2'b00, b ? db_oe : da_oe}, '0);
    pe(b);
    chk(b ? {ib_o, db_o} : {ia_o, da_o}, pa.enc(w1));
    pe(b);
    chk({b ? ib_oe : ia_oe, b ? db_oe : da_oe}, {(W+2){1'b1}});
  endtask
  task automatic wr(input bit b, input logic cf, input logic [5:0] ad, input logic [W-1:0] w0,
                    input logic [W-1:0] w1);
    cmd(b, 1'b0, 1'b0, cf, ad);
    if (b) begin
      pb.send(w0, w1);
    end else begin
      pa.send(w0, w1);
    end
    repeat (6) pe(b);
  endtask
  task automatic t_rst();
    chk({qva, qvb, qca, qcb, da_oe[W-1:W-8], mode}, {8'h00, 8'hff, 8'h00});
  endtask
  task automatic t_both();
    wr(1'b0, 1'b1, 6'h03, 36'h0_0000_0001, 36'h8_0001_ffff);
    wr(1'b1, 1'b1, 6'h05, 36'ha_5a5a_5a5a, 36'h0_0000_0000);
    fork
      rd(1'b0, 6'h05, 36'ha_5a5a_5a5a, 36'h0_0000_0000);
      rd(1'b1, 6'h03, 36'h0_0000_0001, 36'h8_0001_ffff);
    join
  endtask
  task automatic t_ign();
    cmd(1'b0, 1'b1, 1'b0, 1'b1, 6'h03);
    pa.send(36'h1_2345_6789, 36'h1_2345_6789);
    cmd(1'b0, 1'b1, 1'b1, 1'b1, 6'h03);
    repeat (6) pe(1'b0);
    chk({2'b00, da_oe}, {2'b00, {W{1'b1}}});
    rd(1'b0, 6'h03, 36'h0_0000_0001, 36'h8_0001_ffff);
  endtask
  task automatic t_cfg();
    wr(1'b0, 1'b0, 6'h00, 36'h0_0000_00c3, 36'h0_0000_0000);
    repeat (10) @(posedge clk);
    chk({30'h0000_0000, mode}, {30'h0000_0000, 8'hc3});
    // register read back on the other port: low byte and lane 0 flag driven, rest released
    cmd(1'b1, 1'b0, 1'b1, 1'b0, 6'h00);
    repeat (5) pe(1'b1);
    chk({ib_oe, db_oe}, {2'b10, 28'hfff_ffff, 8'h00});
    chk({ib_o, db_o[7:0]}, {2'b00, 8'hc3});
  endtask
  task automatic t_arst();
    cmd(1'b0, 1'b0, 1'b1, 1'b1, 6'h03);
    repeat (4) pe(1'b0);
    reset_n <= 1'b0;
    #1;
    chk({qva, ia_oe, da_oe}, {2'b00, {(W+2){1'b1}}});
    repeat (2) pe(1'b0);
    reset_n <= 1'b1;
    // the array keeps its contents; a read after release proves the port is back
    rd(1'b0, 6'h03, 36'h0_0000_0001, 36'h8_0001_ffff);
  endtask
  initial begin
    #20000;
    fail_count++;
    test_done();
  end
  initial begin
    repeat (6) @(negedge clk);
    sys_rst <= 1'b0;
    t_rst();
    reset_n <= 1'b1;
    t_both();
    t_ign();
    t_cfg();
    t_arst();
    repeat (4) @(negedge clk);
    test_done();
  end
endmodule
bind dps_top dps_chk #(.WIDE_BUS(WIDE_BUS)) u_chk (
  .clk(clk),
  .sys_rst(sys_rst),
  .command_clock(command_clock),
  .reset_n(reset_n),
  .config_select_n(config_select_n),
  .load_strobe_a_n(load_strobe_a_n),
  .read_write_sel_a_n(read_write_sel_a_n),
  .load_strobe_b_n(load_strobe_b_n),
  .read_write_sel_b_n(read_write_sel_b_n),
  .read_clock_port_a(read_clock_port_a),
  .read_clock_port_b(read_clock_port_b),
  .read_valid_port_a(read_valid_port_a),
  .read_valid_port_b(read_valid_port_b),
  .data_bus_port_a_oe_n(data_bus_port_a_oe_n),
  .data_invert_port_a_oe_n(data_invert_port_a_oe_n)
);
